// ==== hw/spec_top.sv ====
//////////////////////////////////////////////////////////////////////////////
// Functional notes
// [R1] after power-up the enable output stays released while periods are short
// [R2] pull enable output low after 63 consecutive periods above disable interval
// [R3] any period below the disable interval clears the disable run count
// [R4] once low, stay low until periods shorter than enable interval occur
// [R5] release enable output after 32 cumulative periods below enable interval
// [R6] while low, long periods never reset the re-enable count
// [R7] droop wake-up leaves enable output and both counts unchanged
// [R8] in either output state a droop raises wake alert on wake pin
// [R9] enable output is open drain: drive low or float, never drive high
// [R10] qualified cycle pulse only if wake pin stayed low past minimum time
// [R11] repeat wake pulses until a power cycle is seen or lockout
// [R12] everything held disabled while supply is under lockout
// [R13] period is time between qualified pulses, classified against both intervals
//////////////////////////////////////////////////////////////////////////////
module spec_top #(
    parameter int unsigned DISABLE_CYCLES = spec_pkg::DISABLE_QUALIFY_CYCLES,
    parameter int unsigned ENABLE_CYCLES  = spec_pkg::ENABLE_QUALIFY_CYCLES,
    parameter int unsigned PER_W          = 20
) (
    // clock and reset
    input  wire logic CLK_SYS_IN,
    input  wire logic RST_IN,
    // supply monitor
    input  wire logic UVLO_OK_IN,
    input  wire logic DROOP_IN,
    // wake pin sense and demag end
    input  wire logic WAKE_BELOW_IN,
    input  wire logic DEMAG_END_IN,
    // wake pin driver
    output logic      WAKE_OUT,
    output logic      WAKE_OE_OUT,
    // enable pin driver
    output logic      SECONDARY_ENABLE_OUT,
    output logic      SECONDARY_ENABLE_OE_OUT,
    // qualified cycle pulse
    output logic      POWER_CYCLE_DETECT_OUT
);
    typedef enum logic [1:0] {
        SPE_RELEASED = 2'b01,
        SPE_LOW      = 2'b10
    } spec_state_e;

    localparam int unsigned QW = 8;
    localparam int unsigned WW = 12;

    spec_state_e      state_ff;
    logic [QW-1:0]    below_cnt_ff;
    logic [PER_W-1:0] per_cnt_ff;
    logic             seen_first_ff;
    logic [5:0]       dis_cnt_ff;
    logic [5:0]       en_cnt_ff;
    logic             wake_req_ff;
    logic [WW-1:0]    wake_cnt_ff;
    logic             pcd_ff;
    logic             wake_drv_ff;
    logic             pcd_now;
    logic             is_long;
    logic             is_short;
    logic             demag_prev_ff;
    logic             demag_rise;
    logic             droop_prev_ff;
    logic             droop_rise;
    logic             wake_start;
    logic             release_now;

    //////////////////////////////////////////////////////////////////////////
    // qualifying timer on the wake pin
    always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
        if (RST_IN) begin
            below_cnt_ff <= 8'h00;
        end else if (!UVLO_OK_IN || !WAKE_BELOW_IN || wake_drv_ff) begin
            below_cnt_ff <= 8'h00;
        end else if (below_cnt_ff <= QW'(spec_pkg::PCD_MIN_CYCLES)) begin
            below_cnt_ff <= below_cnt_ff + 8'h01;
        end
    end

    // only the leading edge of demag end counts, so a stretched strobe cannot
    // produce two detections in a row
    always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
        if (RST_IN) begin
            demag_prev_ff <= 1'b0;
        end else begin
            demag_prev_ff <= DEMAG_END_IN;
        end
    end
    assign demag_rise = DEMAG_END_IN && !demag_prev_ff;

    // strictly longer than the minimum qualifying time
    assign pcd_now = UVLO_OK_IN && demag_rise &&
                     (below_cnt_ff > QW'(spec_pkg::PCD_MIN_CYCLES)); // [R10]

    always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
        if (RST_IN) begin
            pcd_ff <= 1'b0;
        end else begin
            pcd_ff <= pcd_now; // [R10]
        end
    end
    assign POWER_CYCLE_DETECT_OUT = pcd_ff;

    //////////////////////////////////////////////////////////////////////////
    // period measurement; saturates so very long gaps still count as long
    always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
        if (RST_IN) begin
            per_cnt_ff    <= '0;
            seen_first_ff <= 1'b0;
        end else if (!UVLO_OK_IN) begin
            per_cnt_ff    <= '0; // [R12]
            seen_first_ff <= 1'b0;
        end else if (pcd_now) begin
            per_cnt_ff    <= '0; // [R13]
            seen_first_ff <= 1'b1;
        end else if (per_cnt_ff != '1) begin
            per_cnt_ff <= per_cnt_ff + PER_W'(1);
        end
    end

    assign is_long  = seen_first_ff && (per_cnt_ff > PER_W'(DISABLE_CYCLES)); // [R13]
    assign is_short = seen_first_ff && (per_cnt_ff < PER_W'(ENABLE_CYCLES));  // [R13]

    //////////////////////////////////////////////////////////////////////////
    // enable output state and counts; droop is not an input here [R7]
    always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
        if (RST_IN) begin
            state_ff   <= SPE_RELEASED; // [R1]
            dis_cnt_ff <= 6'h00;
            en_cnt_ff  <= 6'h00;
        end else if (!UVLO_OK_IN) begin
            state_ff   <= SPE_RELEASED; // [R12]
            dis_cnt_ff <= 6'h00;
            en_cnt_ff  <= 6'h00;
        end else if (pcd_now && seen_first_ff) begin
            unique case (state_ff)
                SPE_RELEASED: begin
                    if (!is_long) begin
                        dis_cnt_ff <= 6'h00; // [R3]
                    end else if (dis_cnt_ff == 6'(spec_pkg::DISABLE_RUN_COUNT - 1)) begin
                        state_ff   <= SPE_LOW; // [R2]
                        dis_cnt_ff <= 6'h00;
                        en_cnt_ff  <= 6'h00;
                    end else begin
                        dis_cnt_ff <= dis_cnt_ff + 6'h01;
                    end
                end
                SPE_LOW: begin
                    // long periods leave the cumulative count alone [R6]
                    if (is_short) begin
                        if (en_cnt_ff == 6'(spec_pkg::ENABLE_CUM_COUNT - 1)) begin
                            state_ff  <= SPE_RELEASED; // [R5]
                            en_cnt_ff <= 6'h00;
                        end else begin
                            en_cnt_ff <= en_cnt_ff + 6'h01; // [R4]
                        end
                    end
                end
                default: begin
                    state_ff <= SPE_RELEASED;
                end
            endcase
        end
    end

    // the 32nd short period drops the switch on the same edge as the state
    assign release_now = pcd_now && is_short &&
                         (en_cnt_ff == 6'(spec_pkg::ENABLE_CUM_COUNT - 1)); // [R5]

    // open drain: data is always low, enable decides [R9]
    always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
        if (RST_IN) begin
            SECONDARY_ENABLE_OUT    <= 1'b0;
            SECONDARY_ENABLE_OE_OUT <= 1'b0;
        end else begin
            SECONDARY_ENABLE_OUT    <= 1'b0; // [R9]
            SECONDARY_ENABLE_OE_OUT <= UVLO_OK_IN && (state_ff == SPE_LOW) && !release_now; // [R9]
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // wake pulse train, independent of enable state
    // idle level of the droop flag is low, so the reset value cannot fake an edge
    always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
        if (RST_IN) begin
            droop_prev_ff <= 1'b0;
        end else begin
            droop_prev_ff <= DROOP_IN;
        end
    end
    // a fresh droop in the gap of a running train starts a pulse at once
    assign droop_rise = DROOP_IN && !droop_prev_ff;
    assign wake_start = UVLO_OK_IN && droop_rise && !wake_drv_ff;

    // droop wins over a detection in the same cycle, so no alert is lost
    always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
        if (RST_IN) begin
            wake_req_ff <= 1'b0;
            wake_cnt_ff <= '0;
        end else if (!UVLO_OK_IN) begin
            wake_req_ff <= 1'b0; // [R12]
            wake_cnt_ff <= '0;
        end else if (wake_start) begin
            wake_req_ff <= 1'b1; // [R8]
            wake_cnt_ff <= WW'(1);
        end else if (pcd_now && !DROOP_IN) begin
            wake_req_ff <= 1'b0; // [R11]
            wake_cnt_ff <= '0;
        end else if (DROOP_IN || wake_req_ff) begin
            wake_req_ff <= 1'b1; // [R8]
            if (wake_cnt_ff == WW'(spec_pkg::WAKE_REPEAT_CYCLES - 1)) begin
                wake_cnt_ff <= '0; // [R11]
            end else begin
                wake_cnt_ff <= wake_cnt_ff + WW'(1);
            end
        end
    end

    // pulse width is bounded by the counter to limit switch dissipation
    always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
        if (RST_IN) begin
            wake_drv_ff <= 1'b0;
            WAKE_OUT    <= 1'b0;
        end else begin
            wake_drv_ff <= wake_start || (UVLO_OK_IN && (DROOP_IN || (wake_req_ff && !pcd_now)) &&
                           (wake_cnt_ff < WW'(spec_pkg::WAKE_PULSE_CYCLES))); // [R8]
            WAKE_OUT    <= 1'b0; // [R9]
        end
    end
    assign WAKE_OE_OUT = wake_drv_ff;
endmodule

// ==== hw/spec_pkg.sv ====
package spec_pkg;
    // period interval limits in microseconds, plain defaults
    localparam int unsigned DISABLE_QUALIFY_INTERVAL_US = 100;
    localparam int unsigned ENABLE_QUALIFY_INTERVAL_US  = 50;
    localparam int unsigned CLK_MHZ                     = 50;
    localparam int unsigned DISABLE_QUALIFY_CYCLES = DISABLE_QUALIFY_INTERVAL_US * CLK_MHZ;
    localparam int unsigned ENABLE_QUALIFY_CYCLES  = ENABLE_QUALIFY_INTERVAL_US * CLK_MHZ;
    // least time the wake pin must sit below threshold before a cycle qualifies
    localparam int unsigned PCD_MIN_NS     = 200;
    localparam int unsigned PCD_MIN_CYCLES = (PCD_MIN_NS + 19) / 20;
    // wake pulse width and repeat period (33 kHz repeat)
    localparam int unsigned WAKE_PULSE_NS     = 1000;
    localparam int unsigned WAKE_PULSE_CYCLES = WAKE_PULSE_NS / 20;
    localparam int unsigned WAKE_REPEAT_NS    = 30000;
    localparam int unsigned WAKE_REPEAT_CYCLES = WAKE_REPEAT_NS / 20;
    localparam int unsigned DISABLE_RUN_COUNT  = 63;
    localparam int unsigned ENABLE_CUM_COUNT   = 32;
endpackage

// ==== tb/spec_monitor.sv ====
module spec_monitor (
    input wire logic CLK_SYS_IN,
    input wire logic RST_IN,
    input wire logic UVLO_OK_IN,
    input wire logic DROOP_IN,
    input wire logic WAKE_BELOW_IN,
    input wire logic DEMAG_END_IN,
    input wire logic WAKE_OUT,
    input wire logic WAKE_OE_OUT,
    input wire logic SECONDARY_ENABLE_OUT,
    input wire logic SECONDARY_ENABLE_OE_OUT,
    input wire logic POWER_CYCLE_DETECT_OUT
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge CLK_SYS_IN); endclocking
    default disable iff (RST_IN);
    // length of the wake pulse in progress, wraps if stuck high
    logic [7:0] wake_len_ff;
    always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
        if (RST_IN)
            wake_len_ff <= 8'h00;
        else
            wake_len_ff <= WAKE_OE_OUT ? wake_len_ff + 8'h01 : 8'h00;
    end
    ////////////////////////////////////////////////////////////
    open_drain_a: assert property (!WAKE_OUT && !SECONDARY_ENABLE_OUT)
        else $error("pin driven high");
    pulse_once_a: assert property (POWER_CYCLE_DETECT_OUT |=> !POWER_CYCLE_DETECT_OUT)
        else $error("detect pulse too long");
    pulse_cause_a: assert property (POWER_CYCLE_DETECT_OUT |-> $past(DEMAG_END_IN) && $past(UVLO_OK_IN)
        && $past(WAKE_BELOW_IN, 2) && $past(WAKE_BELOW_IN, 11)) else $error("unqualified detect pulse");
    uvlo_hold_a: assert property (!UVLO_OK_IN |=> !SECONDARY_ENABLE_OE_OUT && !WAKE_OE_OUT)
        else $error("output active under lockout");
    enable_cause_a: assert property ($changed(SECONDARY_ENABLE_OE_OUT) |-> $past(DEMAG_END_IN)
        || $past(POWER_CYCLE_DETECT_OUT) || !$past(UVLO_OK_IN)) else $error("enable moved without cycle");
    wake_start_a: assert property ($rose(DROOP_IN) && UVLO_OK_IN && !WAKE_OE_OUT |=> WAKE_OE_OUT)
        else $error("droop gave no wake");
    wake_width_a: assert property ($fell(WAKE_OE_OUT) && $past(UVLO_OK_IN)
        |-> wake_len_ff == 8'(spec_pkg::WAKE_PULSE_CYCLES)) else $error("wake pulse width");
    wake_gap_a: assert property ($fell(WAKE_OE_OUT) |-> !WAKE_OE_OUT [*8])
        else $error("wake pulses too close");
endmodule
bind spec_top spec_monitor u_mon (.CLK_SYS_IN(CLK_SYS_IN), .RST_IN(RST_IN), .UVLO_OK_IN(UVLO_OK_IN),
    .DROOP_IN(DROOP_IN), .WAKE_BELOW_IN(WAKE_BELOW_IN), .DEMAG_END_IN(DEMAG_END_IN), .WAKE_OUT(WAKE_OUT),
    .WAKE_OE_OUT(WAKE_OE_OUT), .SECONDARY_ENABLE_OUT(SECONDARY_ENABLE_OUT),
    .SECONDARY_ENABLE_OE_OUT(SECONDARY_ENABLE_OE_OUT), .POWER_CYCLE_DETECT_OUT(POWER_CYCLE_DETECT_OUT));

// ==== tb/spec_converter_model.sv ====
module spec_converter_model (
    input  wire logic clk_in,
    output logic      wake_below_out,
    output logic      demag_end_out
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        wake_below_out = 1'b0;
        demag_end_out  = 1'b0;
    end
    // one power cycle of p clocks: ringing, a quiet window of 14, then demag end
    task automatic cycle(input int p, input bit quiet);
        wake_below_out = 1'b0;
        repeat (p - 15) @(negedge clk_in);
        wake_below_out = quiet;
        repeat (14) @(negedge clk_in);
        demag_end_out = 1'b1;
        @(negedge clk_in);
        demag_end_out = 1'b0;
    endtask
endmodule

// ==== tb/switching_period_enable_counter_test.sv ====
module switching_period_enable_counter_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk, rst, uvlo_ok, droop, wake, wake_oe, en, en_oe, cyc_det;
    wire  below_m, demag;
    // wake pin is below threshold whenever our own switch pulls it down
    wire  below = below_m | wake_oe;
    int   bad_count = 0, compares = 0, det_count = 0;
    spec_top #(.DISABLE_CYCLES(50), .ENABLE_CYCLES(25)) DUT (.CLK_SYS_IN(clk), .RST_IN(rst), .UVLO_OK_IN(uvlo_ok),
        .DROOP_IN(droop), .WAKE_BELOW_IN(below), .DEMAG_END_IN(demag), .WAKE_OUT(wake), .WAKE_OE_OUT(wake_oe),
        .SECONDARY_ENABLE_OUT(en), .SECONDARY_ENABLE_OE_OUT(en_oe), .POWER_CYCLE_DETECT_OUT(cyc_det));
    spec_converter_model conv (.clk_in(clk), .wake_below_out(below_m), .demag_end_out(demag));
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    always @(posedge clk) if (cyc_det === 1'b1) det_count++;
    ////////////////////////////////////////////////////////////
    task automatic check(input logic got, input logic exp);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: got %b expected %b", $time, got, exp);
        end
    endtask
    task automatic end_sim();
        $display("compares %0d, mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic run(input int n, input int p);
        repeat (n) conv.cycle(p, 1'b1);
        repeat (2) @(negedge clk);
    endtask
    ////////////////////////////////////////////////////////////
    task automatic t_power_up();
        run(70, 40);
        check(en_oe, 1'b0);
        check(en, 1'b0);
        check(wake, 1'b0);
        check(det_count == 70, 1'b1);
    endtask
    task automatic t_disable();
        run(62, 60);
        run(1, 40);
        run(62, 60);
        check(en_oe, 1'b0);
        run(1, 60);
        check(en_oe, 1'b1);
    endtask
    task automatic t_uvlo();
        uvlo_ok = 1'b0;
        repeat (2) @(negedge clk);
        check(en_oe, 1'b0);
        uvlo_ok = 1'b1;
    endtask
    task automatic t_reenable();
        repeat (31) begin
            conv.cycle(20, 1'b1);
            conv.cycle(60, 1'b1);
        end
        check(en_oe, 1'b1);
        droop = 1'b1;
        repeat (2) @(negedge clk);
        droop = 1'b0;
        check(wake_oe, 1'b1);
        check(en_oe, 1'b1);
        repeat (60) @(negedge clk);
        run(1, 20);
        check(en_oe, 1'b1);
        run(1, 20);
        check(en_oe, 1'b0);
    endtask
    task automatic t_unqual();
        int n;
        n = det_count;
        conv.cycle(20, 1'b0);
        repeat (2) @(negedge clk);
        check(det_count == n, 1'b1);
    endtask
    // pulse repeats every 1500 clocks until a detection stops the train
    task automatic t_wake();
        int n;
        droop = 1'b1;
        @(negedge clk);
        droop = 1'b0;
        check(wake_oe, 1'b1);
        repeat (1490) @(negedge clk);
        check(wake_oe, 1'b0);
        repeat (20) @(negedge clk);
        check(wake_oe, 1'b1);
        n = det_count;
        conv.cycle(60, 1'b1);
        repeat (1450) @(negedge clk);
        check(wake_oe, 1'b0);
        check(det_count == n + 1, 1'b1);
    endtask
    ////////////////////////////////////////////////////////////
    initial begin
        rst = 1'b1;
        uvlo_ok = 1'b1;
        droop = 1'b0;
        repeat (10) @(negedge clk);
        rst = 1'b0;
        t_power_up();
        t_disable();
        t_uvlo();
        t_disable();
        t_reenable();
        t_unqual();
        t_wake();
        end_sim();
    end
    // whole run is about 25k clocks, so 1 ms leaves ample margin
    initial begin
        #1000000;
        bad_count++;
        end_sim();
    end
endmodule
